// ==== gdt_timing_regs.sv ====
// gdt_timing_regs: gate driver threshold and timing register bank
// Contract
// RULE_01: timing bit 7 floats all switch drivers
// RULE_02: retry field bits 6-5, 2/4/6/8 ms
// RULE_03: dead time bits 4-3, 500-4000 ns
// RULE_04: bit 2 enables 20 us drive cap
// RULE_05: gate current codes 0-3 force cap
// RULE_06: drive time bits 1-0, 500-3000 ns
// RULE_07: phase B low threshold, reset 1001b
// RULE_08: phase B high threshold, same mapping
// RULE_09: phase C low threshold, reset 1001b
// RULE_10: phase C high threshold, same mapping
// RULE_11: phase C register 0x0B, reset 0x99
// RULE_12: timing register 0x0C, reset 0x2F
// RULE_13: phase B register 0x0A, reset 0x99
// RULE_14: locked code blocks writes until unlock
// RULE_15: retry wait used in retry mode
// RULE_16: dead time between complementary switches
// RULE_17: new settings apply at next switch
// assumes an APB master on clk; zero-wait slave, unmapped reads zero
`timescale 1ns/100ps
`default_nettype none
module gdt_timing_regs
	import gdt_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] gate_current_setting,
	input wire logic [1:0] overcurrent_handling_mode,
	input wire logic drain_source_overcurrent,
	input wire logic pwm_b,
	input wire logic pwm_c,
	output logic b_hs_on,
	output logic b_ls_on,
	output logic b_peak,
	output logic c_hs_on,
	output logic c_ls_on,
	output logic c_peak,
	output logic [10:0] phase_b_low_threshold,
	output logic [10:0] phase_b_high_threshold,
	output logic [10:0] phase_c_low_threshold,
	output logic [10:0] phase_c_high_threshold,
	output logic fault_active
);
	//--------------------------------------------------------------
	// register bank
	//--------------------------------------------------------------
	logic [7:0] vds_threshold_phase_b_q;
	logic [7:0] vds_threshold_phase_c_q;
	logic [7:0] gate_timing_control_q;
	logic [2:0] lock_q;
	logic wr_en;
	logic rd_en;
	logic locked;
	logic [7:0] wbyte;
	logic max_force;
	logic [1:0] retry_code;
	logic [23:0] retry_cyc;
	logic [23:0] retry_cnt_q;
	logic fault_q;
	gdt_cfg_if cfg_bus ();

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign wbyte = pwdata[7:0];
	assign locked = (lock_q == LOCK_CODE);
	assign pready = 1'b1; // every access finishes in its first access cycle
	assign pslverr = 1'b0;

	// lock field: only unlock code leaves the locked state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lock_q <= UNLOCK_CODE;
		end else if (wr_en && paddr == ADDR_LOCK) begin
			if (locked && wbyte[LOCK_LSB +: 3] == UNLOCK_CODE) begin
				lock_q <= UNLOCK_CODE; // [RULE_14]
			end else if (!locked && wbyte[LOCK_LSB +: 3] == LOCK_CODE) begin
				lock_q <= LOCK_CODE; // [RULE_14]
			end
		end
	end

	// threshold registers; writes dropped while locked
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vds_threshold_phase_b_q <= RST_PH_B; // [RULE_13] [RULE_07] [RULE_08]
			vds_threshold_phase_c_q <= RST_PH_C; // [RULE_11] [RULE_09] [RULE_10]
		end else if (wr_en && !locked) begin // [RULE_14]
			if (paddr == ADDR_PH_B) begin
				vds_threshold_phase_b_q <= wbyte; // [RULE_13]
			end
			if (paddr == ADDR_PH_C) begin
				vds_threshold_phase_c_q <= wbyte; // [RULE_11]
			end
		end
	end

	// low gate currents cannot run without the drive-time cap
	assign max_force = (gate_current_setting <= IDRV_FORCE_MAX); // [RULE_05]

	// timing register; cap bit reasserted by hardware, so hardware wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gate_timing_control_q <= RST_TIMING; // [RULE_12]
		end else begin
			if (wr_en && !locked && paddr == ADDR_TIMING) begin // [RULE_14]
				gate_timing_control_q <= wbyte; // [RULE_12]
				if (max_force) begin
					gate_timing_control_q[TMAX_BIT] <= 1'b1; // [RULE_05]
				end
			end else if (max_force) begin
				gate_timing_control_q[TMAX_BIT] <= 1'b1; // [RULE_05]
			end
		end
	end

	// read mux; registered output, unmapped addresses read zero
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en && !penable) begin
			unique case (paddr)
				ADDR_PH_B: prdata <= {24'h000000, vds_threshold_phase_b_q};
				ADDR_PH_C: prdata <= {24'h000000, vds_threshold_phase_c_q};
				ADDR_TIMING: prdata <= {24'h000000, gate_timing_control_q};
				ADDR_LOCK: prdata <= {24'h000000, lock_q, 5'h00};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	//--------------------------------------------------------------
	// field decode
	//--------------------------------------------------------------
	// thresholds in millivolts, one shared table
	assign phase_b_low_threshold = vds_mv(vds_threshold_phase_b_q[LOW_LSB +: 4]); // [RULE_07]
	assign phase_b_high_threshold = vds_mv(vds_threshold_phase_b_q[HIGH_LSB +: 4]); // [RULE_08]
	assign phase_c_low_threshold = vds_mv(vds_threshold_phase_c_q[LOW_LSB +: 4]); // [RULE_09]
	assign phase_c_high_threshold = vds_mv(vds_threshold_phase_c_q[HIGH_LSB +: 4]); // [RULE_10]

	// dead time and drive time cycle counts
	always_comb begin
		unique case (gate_timing_control_q[DEAD_LSB +: 2])
			2'h0: cfg_bus.dead_cyc = DEAD_00; // [RULE_03]
			2'h1: cfg_bus.dead_cyc = DEAD_01;
			2'h2: cfg_bus.dead_cyc = DEAD_10;
			2'h3: cfg_bus.dead_cyc = DEAD_11;
		endcase
		unique case (gate_timing_control_q[TDRV_LSB +: 2])
			2'h0: cfg_bus.drive_cyc = DEAD_00; // [RULE_06]
			2'h1: cfg_bus.drive_cyc = DEAD_01;
			2'h2: cfg_bus.drive_cyc = DEAD_10;
			2'h3: cfg_bus.drive_cyc = TDRV_11;
		endcase
	end
	assign cfg_bus.max_en = gate_timing_control_q[TMAX_BIT] || max_force; // [RULE_04]
	assign cfg_bus.float_all = gate_timing_control_q[FLOAT_BIT]; // [RULE_01]

	//--------------------------------------------------------------
	// fault retry
	//--------------------------------------------------------------
	// wait is (code+1) steps of 2 ms
	assign retry_code = gate_timing_control_q[RETRY_LSB +: 2];
	assign retry_cyc = 24'((32'(retry_code) + 32'd1) * RETRY_STEP_CYC); // [RULE_02]

	// only retry mode clears the fault by itself; other modes stay latched
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fault_q <= 1'b0;
			retry_cnt_q <= 24'h000000;
		end else if (drain_source_overcurrent) begin
			fault_q <= 1'b1; // new fault wins over clear
			retry_cnt_q <= 24'h000000;
		end else if (fault_q && overcurrent_handling_mode == MODE_RETRY) begin
			if (retry_cnt_q + 24'h000001 >= retry_cyc) begin
				fault_q <= 1'b0; // [RULE_15]
				retry_cnt_q <= 24'h000000;
			end else begin
				retry_cnt_q <= retry_cnt_q + 24'h000001;
			end
		end
	end
	assign fault_active = fault_q;

	//--------------------------------------------------------------
	// half-bridges; only the float bit floats the bridge, a fault does not
	//--------------------------------------------------------------
	gdt_half_bridge u_b (
		.clk(clk),
		.nrst(nrst),
		.cfg(cfg_bus),
		.pwm_hi(pwm_b),
		.hs_on(b_hs_on),
		.ls_on(b_ls_on),
		.peak_drive(b_peak)
	);
	gdt_half_bridge u_c (
		.clk(clk),
		.nrst(nrst),
		.cfg(cfg_bus),
		.pwm_hi(pwm_c),
		.hs_on(c_hs_on),
		.ls_on(c_ls_on),
		.peak_drive(c_peak)
	);

	AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (!nrst)
		locked && wr_en && paddr == ADDR_PH_C |=> $stable(vds_threshold_phase_c_q))
		else $error("write while locked"); // [RULE_14]
	AST_FORCE_MAX: assert property (@(posedge clk) disable iff (!nrst)
		max_force |=> gate_timing_control_q[TMAX_BIT]) else $error("cap not forced"); // [RULE_05]
	AST_WR_TIMING: assert property (@(posedge clk) disable iff (!nrst)
		wr_en && !locked && paddr == ADDR_TIMING && !max_force
		|=> gate_timing_control_q == $past(wbyte)) else $error("timing write lost"); // [RULE_12]
	AST_RETRY_CLR: assert property (@(posedge clk) disable iff (!nrst)
		$fell(fault_q) |-> $past(overcurrent_handling_mode) == MODE_RETRY)
		else $error("fault cleared outside retry"); // [RULE_15]
	AST_THR_MAP: assert property (@(posedge clk) disable iff (!nrst)
		vds_threshold_phase_c_q[LOW_LSB +: 4] == 4'h9 |-> phase_c_low_threshold == 11'd750)
		else $error("threshold map wrong"); // [RULE_09]
endmodule : gdt_timing_regs
`default_nettype wire

// ==== gdt_pkg.sv ====
// gdt_pkg: register map, field layout, reset values and timing constants
// assumes a 25 MHz core clock
package gdt_pkg;
	localparam int CLK_MHZ = 25;
	localparam logic [11:0] ADDR_PH_B = 12'h028; // index 0x0A
	localparam logic [11:0] ADDR_PH_C = 12'h02C; // index 0x0B
	localparam logic [11:0] ADDR_TIMING = 12'h030; // index 0x0C
	localparam logic [11:0] ADDR_LOCK = 12'h034; // index 0x0D
	localparam logic [7:0] RST_PH_B = 8'h99;
	localparam logic [7:0] RST_PH_C = 8'h99;
	localparam logic [7:0] RST_TIMING = 8'h2F;
	localparam logic [2:0] LOCK_CODE = 3'h6;
	localparam logic [2:0] UNLOCK_CODE = 3'h3;
	localparam int LOCK_LSB = 5;
	localparam int FLOAT_BIT = 7;
	localparam int RETRY_LSB = 5;
	localparam int DEAD_LSB = 3;
	localparam int TMAX_BIT = 2;
	localparam int TDRV_LSB = 0;
	localparam int LOW_LSB = 4;
	localparam int HIGH_LSB = 0;
	localparam logic [3:0] IDRV_FORCE_MAX = 4'h3;
	localparam logic [1:0] MODE_RETRY = 2'h1;
	// retry step and cap in their own unit, cycles derived; dead and drive times given in cycles
	localparam int RETRY_STEP_MS = 2;
	localparam int RETRY_STEP_CYC = RETRY_STEP_MS * 1000 * CLK_MHZ;
	localparam int DRV_MAX_US = 20;
	localparam int DRV_MAX_CYC = DRV_MAX_US * CLK_MHZ;
	localparam int NS500_CYC = (500 * CLK_MHZ + 999) / 1000; // rounded up
	localparam logic [7:0] DEAD_00 = 8'd13;
	localparam logic [7:0] DEAD_01 = 8'd25;
	localparam logic [7:0] DEAD_10 = 8'd50;
	localparam logic [7:0] DEAD_11 = 8'd100;
	localparam logic [7:0] TDRV_11 = 8'd75;
	typedef enum logic [1:0] {PH_OFF, PH_DEAD, PH_ON} phase_t;
	// threshold code to millivolts, shared by every phase field
	function automatic logic [10:0] vds_mv(input logic [3:0] code);
		unique case (code)
			4'h0: vds_mv = 11'd60;
			4'h1: vds_mv = 11'd130;
			4'h2: vds_mv = 11'd200;
			4'h3: vds_mv = 11'd260;
			4'h4: vds_mv = 11'd310;
			4'h5: vds_mv = 11'd450;
			4'h6: vds_mv = 11'd530;
			4'h7: vds_mv = 11'd600;
			4'h8: vds_mv = 11'd680;
			4'h9: vds_mv = 11'd750;
			4'hA: vds_mv = 11'd940;
			4'hB: vds_mv = 11'd1130;
			4'hC: vds_mv = 11'd1300;
			4'hD: vds_mv = 11'd1500;
			4'hE: vds_mv = 11'd1700;
			4'hF: vds_mv = 11'd1880;
		endcase
	endfunction : vds_mv
endpackage : gdt_pkg

// ==== gdt_cfg_if.sv ====
// gdt_cfg_if: live timing settings from register bank to half-bridge timers
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface gdt_cfg_if;
	logic [7:0] dead_cyc;
	logic [7:0] drive_cyc;
	logic max_en;
	logic float_all;
	modport bank (output dead_cyc, drive_cyc, max_en, float_all);
	modport bridge (input dead_cyc, drive_cyc, max_en, float_all);
endinterface : gdt_cfg_if
`default_nettype wire

// ==== gdt_half_bridge.sv ====
// gdt_half_bridge: dead time and peak-drive timing for one half-bridge
// assumes pwm_hi is synchronous; settings latched per switching event
`timescale 1ns/100ps
`default_nettype none
module gdt_half_bridge
	import gdt_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	gdt_cfg_if.bridge cfg,
	input wire logic pwm_hi,
	output logic hs_on,
	output logic ls_on,
	output logic peak_drive
);
	phase_t st_q;
	logic side_q;
	logic [7:0] cnt_q;
	logic [7:0] dead_lat_q;
	logic [7:0] drv_lat_q;
	logic [11:0] on_cnt_q;
	logic max_lat_q;

	// switch state: off, dead gap, then on; new settings taken at the edge
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_q <= PH_OFF;
			side_q <= 1'b0;
			cnt_q <= 8'h00;
			dead_lat_q <= 8'h00;
			drv_lat_q <= 8'h00;
			max_lat_q <= 1'b1;
		end else if (cfg.float_all) begin
			st_q <= PH_OFF; // [RULE_01]
		end else if (st_q == PH_OFF || pwm_hi != side_q) begin
			st_q <= PH_DEAD; // [RULE_16]
			side_q <= pwm_hi;
			cnt_q <= 8'h00;
			dead_lat_q <= cfg.dead_cyc; // [RULE_17]
			drv_lat_q <= cfg.drive_cyc; // [RULE_17]
			max_lat_q <= cfg.max_en;
		end else if (st_q == PH_DEAD) begin
			if (cnt_q + 8'h01 >= dead_lat_q) begin
				st_q <= PH_ON;
				cnt_q <= 8'h00;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end else if (cnt_q != 8'hFF) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// on-time guard for the peak drive limit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			on_cnt_q <= 12'h000;
		end else if (st_q != PH_ON) begin
			on_cnt_q <= 12'h000;
		end else if (on_cnt_q != 12'hFFF) begin
			on_cnt_q <= on_cnt_q + 12'h001;
		end
	end

	assign hs_on = (st_q == PH_ON) && side_q;
	assign ls_on = (st_q == PH_ON) && !side_q;
	// peak current ends at the drive time, or the 20 us cap when enabled
	assign peak_drive = (st_q == PH_ON) && (cnt_q < drv_lat_q)
		&& !(max_lat_q && on_cnt_q >= 12'(DRV_MAX_CYC)); // [RULE_04]

	AST_NO_SHOOT: assert property (@(posedge clk) disable iff (!nrst)
		!(hs_on && ls_on)) else $error("both switches on"); // [RULE_16]
	AST_DEAD_GAP: assert property (@(posedge clk) disable iff (!nrst)
		$fell(hs_on) |-> !ls_on [*2]) else $error("no dead gap"); // [RULE_16]
	AST_FLOAT_OFF: assert property (@(posedge clk) disable iff (!nrst)
		cfg.float_all |=> !hs_on && !ls_on) else $error("float ignored"); // [RULE_01]
endmodule : gdt_half_bridge
`default_nettype wire

// ==== test_gdt_timing_regs.sv ====
// test_gdt_timing_regs: directed bench for the threshold and timing register bank
// assumes an APB slave that answers with pready, one 25 MHz clock, nrst async low
`timescale 1ns/100ps
`default_nettype none
module test_gdt_timing_regs
	import gdt_pkg::*;
;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, fault, pwm_b, pwm_c, fault_active;
	logic b_hs, b_ls, b_pk, c_hs, c_ls, c_pk;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] gcs;
	logic [1:0] ocm;
	logic [10:0] th_bl, th_bh, th_cl, th_ch;
	int err_count, check_count;
	// expected millivolts per threshold code, written out independently of the design
	logic [10:0] mv_tab [16] = '{11'd60, 11'd130, 11'd200, 11'd260, 11'd310, 11'd450, 11'd530,
		11'd600, 11'd680, 11'd750, 11'd940, 11'd1130, 11'd1300, 11'd1500, 11'd1700, 11'd1880};
	// dead time in 40 ns cycles, 500 ns rounded up
	int dead_tab [4] = '{13, 25, 50, 100};
	// peak drive time in 40 ns cycles: 500, 1000, 2000, 3000 ns
	int drv_tab [4] = '{13, 25, 50, 75};

	gdt_timing_regs i_gdt_timing_regs (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gate_current_setting(gcs), .overcurrent_handling_mode(ocm),
		.drain_source_overcurrent(fault), .pwm_b(pwm_b), .pwm_c(pwm_c), .b_hs_on(b_hs),
		.b_ls_on(b_ls), .b_peak(b_pk), .c_hs_on(c_hs), .c_ls_on(c_ls), .c_peak(c_pk),
		.phase_b_low_threshold(th_bl), .phase_b_high_threshold(th_bh),
		.phase_c_low_threshold(th_cl), .phase_c_high_threshold(th_ch),
		.fault_active(fault_active));

	// ----------------------------------------
	// clock, compare and bus tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : test_done

	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_word

	task chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit

	// hang guard: a bound that runs out is a mismatch and ends the run
	task timed_out;
		err_count++;
		$display("MISMATCH t=%0t wait bound used up", $time);
		test_done();
	endtask : timed_out

	// one APB transfer; request held until pready is seen high at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (n == 20) timed_out();
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk_word(rd, exp);
	endtask : rdchk

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		chk_word({28'h0, b_hs, b_ls, c_hs, c_ls}, 32'h0);
		chk_bit(fault_active, 1'b0);
		rdchk(ADDR_PH_B, 32'h99);
		rdchk(ADDR_PH_C, 32'h99);
		rdchk(ADDR_TIMING, 32'h2F);
		chk_word({21'h0, th_bl}, 32'd750);
		chk_word({21'h0, th_bh}, 32'd750);
		chk_word({21'h0, th_cl}, 32'd750);
		chk_word({21'h0, th_ch}, 32'd750);
		apb(1'b1, 12'h040, 32'hFF);
		rdchk(12'h040, 32'h0);
		$display("t_reset done");
	endtask : t_reset

	// every code on every field, low and high fields driven in opposite order
	task t_thresh;
		logic [3:0] k;
		for (int i = 0; i < 16; i++) begin
			k = i[3:0];
			apb(1'b1, ADDR_PH_B, {24'h0, k, ~k});
			apb(1'b1, ADDR_PH_C, {24'h0, ~k, k});
			rdchk(ADDR_PH_B, {24'h0, k, ~k});
			rdchk(ADDR_PH_C, {24'h0, ~k, k});
			chk_word({21'h0, th_bl}, {21'h0, mv_tab[k]});
			chk_word({21'h0, th_bh}, {21'h0, mv_tab[~k]});
			chk_word({21'h0, th_cl}, {21'h0, mv_tab[~k]});
			chk_word({21'h0, th_ch}, {21'h0, mv_tab[k]});
		end
		$display("t_thresh done");
	endtask : t_thresh

	// dead time from pwm rise to high side on, then the peak drive length;
	// both bridges switch together, overlap watched until the high side is on
	task t_dead;
		logic [1:0] d;
		logic ovl;
		int n;
		int m;
		gcs <= 4'hF;
		for (int i = 0; i < 4; i++) begin
			d = i[1:0];
			apb(1'b1, ADDR_TIMING, {24'h0, 1'b0, d, d, 1'b1, d});
			rdchk(ADDR_TIMING, {24'h0, 1'b0, d, d, 1'b1, d});
			pwm_b <= 1'b0;
			pwm_c <= 1'b0;
			repeat (150) @(posedge clk);
			pwm_b <= 1'b1;
			pwm_c <= 1'b1;
			ovl = 1'b0;
			for (n = 0; n < 300; n++) begin
				@(posedge clk);
				#1;
				if (b_hs === 1'b1 && b_ls === 1'b1) ovl = 1'b1;
				if (c_hs === 1'b1 && c_ls === 1'b1) ovl = 1'b1;
				if (b_hs === 1'b1) break;
			end
			if (n == 300) timed_out();
			chk_bit(n >= dead_tab[i] - 1 && n <= dead_tab[i] + 2, 1'b1);
			chk_bit(c_hs, 1'b1);
			// peak phase counted from the first cycle the switch is on
			for (m = 0; m < 200; m++) begin
				if (b_pk !== 1'b1 || c_pk !== 1'b1) break;
				@(posedge clk);
				#1;
			end
			chk_bit(m == drv_tab[i], 1'b1);
			chk_bit(ovl, 1'b0);
		end
		$display("t_dead done");
	endtask : t_dead

	task t_float;
		apb(1'b1, ADDR_TIMING, 32'hAF);
		repeat (2) @(posedge clk);
		#1;
		chk_word({28'h0, b_hs, b_ls, c_hs, c_ls}, 32'h0);
		apb(1'b1, ADDR_TIMING, 32'h2F);
		repeat (150) @(posedge clk);
		chk_bit(b_hs, 1'b1);
		chk_bit(c_hs, 1'b1);
		$display("t_float done");
	endtask : t_float

	// low gate current codes force the cap enable back on; others let it clear
	task t_cap;
		for (int g = 0; g < 4; g++) begin
			gcs <= g[3:0];
			apb(1'b1, ADDR_TIMING, 32'h2B);
			rdchk(ADDR_TIMING, 32'h2F);
		end
		gcs <= 4'h4;
		apb(1'b1, ADDR_TIMING, 32'h2B);
		rdchk(ADDR_TIMING, 32'h2B);
		$display("t_cap done");
	endtask : t_cap

	task t_lock;
		apb(1'b1, ADDR_PH_B, 32'h55);
		apb(1'b1, ADDR_LOCK, 32'hC0);
		apb(1'b1, ADDR_PH_B, 32'h12);
		apb(1'b1, ADDR_TIMING, 32'h00);
		apb(1'b1, ADDR_PH_C, 32'h12);
		chk_bit(pslverr, 1'b0);
		rdchk(ADDR_PH_B, 32'h55);
		rdchk(ADDR_TIMING, 32'h2B);
		rdchk(ADDR_PH_C, 32'h0F);
		rdchk(ADDR_LOCK, 32'hC0);
		apb(1'b1, ADDR_LOCK, 32'h40);
		apb(1'b1, ADDR_PH_B, 32'h12);
		rdchk(ADDR_PH_B, 32'h55);
		apb(1'b1, ADDR_LOCK, 32'h60);
		rdchk(ADDR_LOCK, 32'h60);
		apb(1'b1, ADDR_PH_B, 32'h12);
		rdchk(ADDR_PH_B, 32'h12);
		$display("t_lock done");
	endtask : t_lock

	// latched mode must not count; retry mode with the shortest wait then clears at 2 ms
	task t_retry;
		int n;
		ocm <= 2'h0;
		apb(1'b1, ADDR_TIMING, 32'h0F);
		fault <= 1'b1;
		@(posedge clk);
		fault <= 1'b0;
		repeat (2000) @(posedge clk);
		chk_bit(fault_active, 1'b1);
		ocm <= 2'h1;
		for (n = 0; n < 60000; n++) begin
			@(posedge clk);
			if (fault_active === 1'b0) break;
		end
		if (n == 60000) timed_out();
		chk_bit(n >= 49990 && n <= 50010, 1'b1);
		$display("t_retry done");
	endtask : t_retry

	// ----------------------------------------
	// main sequence, second reset after the last scenario
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, fault, pwm_b, pwm_c} = 6'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		gcs = 4'hF;
		ocm = 2'h0;
		err_count = 0;
		check_count = 0;
		nrst = 1'b0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_thresh();
		t_dead();
		t_float();
		t_cap();
		t_lock();
		t_retry();
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		test_done();
	end
endmodule : test_gdt_timing_regs
`default_nettype wire
